// [core/error_log_alarm_unit.sv]
// Error log, user failure alarms, error indicator and interrupt for the controller
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

`include "error_log_regs.svh"

module error_log_alarm_unit #(
    parameter int DEPTH          = `ELOG_DEPTH,
    parameter int NUM_W          = 8,
    parameter int FLASH_HALF_CYC =
        `ELOG_FLASH_HALF_MS * (1000000 / `ELOG_CLK_PERIOD_NS)
) (
    input  wire logic                    core_clk,
    input  wire logic                    rstn,
    input  wire logic                    ce,
    input  wire logic [`ELOG_ADDR_W-1:0] reg_addr,
    input  wire logic [`ELOG_DATA_W-1:0] reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [`ELOG_DATA_W-1:0]      reg_rdata,
    input  wire logic                    sys_err_valid,
    input  wire logic [15:0]             sys_err_code,
    input  wire logic [15:0]             sys_err_detail,
    input  wire logic                    nonfatal_user_alarm,
    input  wire logic [NUM_W-1:0]        nonfatal_alarm_num,
    input  wire logic                    fatal_user_alarm,
    input  wire logic [NUM_W-1:0]        fatal_alarm_num,
    input  wire logic                    err_clear_req,
    output logic                         program_halt,
    output logic                         err_indicator,
    output logic                         irq
);

    localparam int IDX_W = $clog2(DEPTH + 1);
    localparam int FL_W  = $clog2(FLASH_HALF_CYC + 1);

    typedef struct packed {
        logic [15:0]                err_code;
        logic [IDX_W-1:0]           log_ptr;
        logic                       fatal_flag;
        logic                       nonfatal_flag;
        logic [IDX_W-1:0]           log_sel;
        logic [`ELOG_IRQ_W-1:0]     irq_stat;
        logic [`ELOG_IRQ_W-1:0]     irq_en;
        error_log_pkg::ind_state_t  ind_state;
        logic [FL_W-1:0]            flash_cnt;
        logic                       flash_phase;
        logic [`ELOG_DATA_W-1:0]    rdata;
        logic                       halt;
        logic                       ind;
        logic                       irq;
    } unit_state_t;

    unit_state_t s_reg;
    unit_state_t s_next;

    error_log_pkg::log_rec_t new_rec;
    error_log_pkg::log_rec_t rd_rec;
    logic                    ev_log;

    logic wr_ctrl;
    logic clear_hit;
    logic nf_zero;
    logic nf_event;

    always_comb begin
        wr_ctrl   = reg_wr && (reg_addr == `ELOG_OFF_CTRL);
        clear_hit = err_clear_req
                    || (wr_ctrl && reg_wdata[`ELOG_CTRL_CLEAR_BIT]);
        nf_zero   = nonfatal_user_alarm
                    && (nonfatal_alarm_num == '0);
        nf_event  = nonfatal_user_alarm && !nf_zero;
    end

    // One record per cycle: fatal alarm, then system error, then non-fatal
    always_comb begin
        ev_log         = 1'b0;
        new_rec        = '0;
        new_rec.stamp  = `ELOG_TIME_CONST;
        if (fatal_user_alarm) begin
            ev_log         = 1'b1;
            new_rec.code   = `ELOG_FATAL_BASE | 16'(fatal_alarm_num);
            new_rec.detail = 16'(fatal_alarm_num);
        end else if (sys_err_valid) begin
            ev_log         = 1'b1;
            new_rec.code   = sys_err_code;
            new_rec.detail = sys_err_detail;
        end else if (nf_event) begin
            ev_log         = 1'b1;
            new_rec.code   = `ELOG_NFATAL_BASE | 16'(nonfatal_alarm_num);
            new_rec.detail = 16'(nonfatal_alarm_num);
        end
    end

    always_comb begin
        s_next = s_reg;

        // Clears first, so an alarm in the same cycle wins
        if (clear_hit) begin
            s_next.nonfatal_flag = 1'b0;
            s_next.fatal_flag    = 1'b0;
            s_next.err_code      = `ELOG_RESET_CODE;
        end
        if (nf_zero) begin
            s_next.nonfatal_flag = 1'b0;
        end

        if (ev_log) begin
            s_next.err_code = new_rec.code;
            if (s_reg.log_ptr < IDX_W'(DEPTH)) begin
                s_next.log_ptr = s_reg.log_ptr + 1'b1;
            end
        end
        if (fatal_user_alarm) begin
            s_next.fatal_flag = 1'b1;
        end
        if (nf_event) begin
            s_next.nonfatal_flag = 1'b1;
        end

        // Sticky interrupt causes; a new event beats the clear write
        if (reg_wr && (reg_addr == `ELOG_OFF_IRQ_CLR)) begin
            s_next.irq_stat = s_reg.irq_stat
                              & ~reg_wdata[`ELOG_IRQ_W-1:0];
        end
        if (ev_log) begin
            s_next.irq_stat[`ELOG_IRQ_LOGGED] = 1'b1;
            if (s_reg.log_ptr >= IDX_W'(DEPTH)) begin
                s_next.irq_stat[`ELOG_IRQ_OVERFLOW] = 1'b1;
            end
        end
        if (nf_event) begin
            s_next.irq_stat[`ELOG_IRQ_NFATAL] = 1'b1;
        end
        if (fatal_user_alarm) begin
            s_next.irq_stat[`ELOG_IRQ_FATAL] = 1'b1;
        end
        if (reg_wr && (reg_addr == `ELOG_OFF_IRQ_EN)) begin
            s_next.irq_en = reg_wdata[`ELOG_IRQ_W-1:0];
        end
        if (reg_wr && (reg_addr == `ELOG_OFF_LOG_SEL)) begin
            s_next.log_sel = reg_wdata[IDX_W-1:0];
        end

        // Indicator: steady for fatal, flashing for non-fatal
        case (s_reg.ind_state)
            error_log_pkg::IND_OFF: begin
                s_next.flash_cnt   = '0;
                s_next.flash_phase = 1'b1;
            end
            error_log_pkg::IND_FLASH: begin
                if (s_reg.flash_cnt >= FL_W'(FLASH_HALF_CYC - 1)) begin
                    s_next.flash_cnt   = '0;
                    s_next.flash_phase = !s_reg.flash_phase;
                end else begin
                    s_next.flash_cnt = s_reg.flash_cnt + 1'b1;
                end
            end
            error_log_pkg::IND_ON: begin
                s_next.flash_cnt   = '0;
                s_next.flash_phase = 1'b1;
            end
            default: begin
                s_next.flash_cnt   = '0;
                s_next.flash_phase = 1'b1;
            end
        endcase
        if (s_next.fatal_flag) begin
            s_next.ind_state = error_log_pkg::IND_ON;
        end else if (s_next.nonfatal_flag) begin
            s_next.ind_state = error_log_pkg::IND_FLASH;
        end else begin
            s_next.ind_state = error_log_pkg::IND_OFF;
        end
        s_next.ind = (s_next.ind_state == error_log_pkg::IND_ON)
                     || ((s_next.ind_state == error_log_pkg::IND_FLASH)
                         && s_next.flash_phase);

        s_next.halt = s_next.fatal_flag;
        s_next.irq  = |(s_next.irq_stat & s_next.irq_en);

        // Read data stand only in the cycle after the strobe
        s_next.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `ELOG_OFF_ERR_CODE:
                    s_next.rdata = 32'(s_reg.err_code);
                `ELOG_OFF_LOG_PTR:
                    s_next.rdata = 32'(s_reg.log_ptr);
                `ELOG_OFF_FATAL_STAT:
                    s_next.rdata[`ELOG_FATAL_BIT] = s_reg.fatal_flag;
                `ELOG_OFF_NFATAL_STAT:
                    s_next.rdata[`ELOG_NFATAL_BIT] = s_reg.nonfatal_flag;
                `ELOG_OFF_IRQ_STAT:
                    s_next.rdata = 32'(s_reg.irq_stat);
                `ELOG_OFF_IRQ_EN:
                    s_next.rdata = 32'(s_reg.irq_en);
                `ELOG_OFF_LOG_SEL:
                    s_next.rdata = 32'(s_reg.log_sel);
                `ELOG_OFF_LOG_CODE:
                    s_next.rdata = 32'(rd_rec.code);
                `ELOG_OFF_LOG_DETAIL:
                    s_next.rdata = 32'(rd_rec.detail);
                `ELOG_OFF_LOG_TIME:
                    s_next.rdata = 32'(rd_rec.stamp);
                default:
                    s_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg             <= '0;
            s_reg.ind_state   <= error_log_pkg::IND_OFF;
            s_reg.flash_phase <= 1'b1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Record store: slots beyond the pointer are never filled
    error_log_mem #(
        .DEPTH  (DEPTH),
        .IDX_W  (IDX_W)
    ) u_log_mem (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ce       (ce),
        .append   (ev_log),
        .wr_rec   (new_rec),
        .count    (s_reg.log_ptr),
        .rd_idx   (s_reg.log_sel),
        .rd_rec   (rd_rec)
    );

    assign reg_rdata     = s_reg.rdata;
    assign program_halt  = s_reg.halt;
    assign err_indicator = s_reg.ind;
    assign irq           = s_reg.irq;

endmodule : error_log_alarm_unit

`default_nettype wire

// [core/error_log_mem.sv]
// Shifting record memory of the error log with registered read port
`timescale 1ns/10ps
`default_nettype none

module error_log_mem #(
    parameter int DEPTH = 20,
    parameter int IDX_W = 5
) (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire logic                      ce,
    input  wire logic                      append,
    input  wire error_log_pkg::log_rec_t   wr_rec,
    input  wire logic [IDX_W-1:0]          count,
    input  wire logic [IDX_W-1:0]          rd_idx,
    output error_log_pkg::log_rec_t        rd_rec
);

    typedef struct packed {
        error_log_pkg::log_rec_t [DEPTH-1:0] slot;
        error_log_pkg::log_rec_t             rd;
    } mem_state_t;

    mem_state_t s_reg;
    mem_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (append) begin
            if (count >= IDX_W'(DEPTH)) begin
                // Oldest drops out of slot 0, newest lands on top
                for (int i = 0; i < DEPTH - 1; i++) begin
                    s_next.slot[i] = s_reg.slot[i+1];
                end
                s_next.slot[DEPTH-1] = wr_rec;
            end else begin
                s_next.slot[count] = wr_rec;
            end
        end
        if (rd_idx < IDX_W'(DEPTH)) begin
            s_next.rd = s_reg.slot[rd_idx];
        end else begin
            s_next.rd = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign rd_rec = s_reg.rd;

endmodule : error_log_mem

`default_nettype wire

// [core/error_log_pkg.sv]
// Types shared by the error log unit and its record memory
package error_log_pkg;

    typedef logic [15:0] word_t;

    typedef struct packed {
        word_t code;
        word_t detail;
        word_t stamp;
    } log_rec_t;

    typedef enum logic [2:0] {
        IND_OFF   = 3'b001,
        IND_FLASH = 3'b010,
        IND_ON    = 3'b100
    } ind_state_t;

endpackage : error_log_pkg

// [core/error_log_regs.svh]
// Register offsets, field positions, reset values and timing for the error log unit
`ifndef ERROR_LOG_REGS_SVH
`define ERROR_LOG_REGS_SVH

`define ELOG_ADDR_W          8
`define ELOG_DATA_W          32

`define ELOG_OFF_ERR_CODE    8'h00
`define ELOG_OFF_LOG_PTR     8'h04
`define ELOG_OFF_FATAL_STAT  8'h08
`define ELOG_OFF_NFATAL_STAT 8'h0c
`define ELOG_OFF_CTRL        8'h10
`define ELOG_OFF_IRQ_STAT    8'h14
`define ELOG_OFF_IRQ_EN      8'h18
`define ELOG_OFF_IRQ_CLR     8'h1c
`define ELOG_OFF_LOG_SEL     8'h20
`define ELOG_OFF_LOG_CODE    8'h24
`define ELOG_OFF_LOG_DETAIL  8'h28
`define ELOG_OFF_LOG_TIME    8'h2c

`define ELOG_FATAL_BIT       6
`define ELOG_NFATAL_BIT      15
`define ELOG_CTRL_CLEAR_BIT  0

`define ELOG_IRQ_W           4
`define ELOG_IRQ_LOGGED      0
`define ELOG_IRQ_NFATAL      1
`define ELOG_IRQ_FATAL       2
`define ELOG_IRQ_OVERFLOW    3

`define ELOG_DEPTH           20
`define ELOG_TIME_CONST      16'h0101
`define ELOG_NFATAL_BASE     16'h4100
`define ELOG_FATAL_BASE      16'hc100
`define ELOG_RESET_CODE      16'h0000

`define ELOG_CLK_PERIOD_NS   100
`define ELOG_FLASH_HALF_MS   500

`endif

// [tb/error_log_alarm_unit_checker.sv]
// Port-level assertions for the error log and alarm unit
`timescale 1ns/10ps
`default_nettype none
`include "error_log_regs.svh"
module error_log_alarm_unit_checker #(
    parameter int DEPTH          = 20,
    parameter int NUM_W          = 8,
    parameter int FLASH_HALF_CYC = 4
) (
    input wire logic             core_clk,
    input wire logic             rstn,
    input wire logic             ce,
    input wire logic [7:0]       reg_addr,
    input wire logic [31:0]      reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [31:0]      reg_rdata,
    input wire logic             sys_err_valid,
    input wire logic [15:0]      sys_err_code,
    input wire logic [15:0]      sys_err_detail,
    input wire logic             nonfatal_user_alarm,
    input wire logic [NUM_W-1:0] nonfatal_alarm_num,
    input wire logic             fatal_user_alarm,
    input wire logic [NUM_W-1:0] fatal_alarm_num,
    input wire logic             err_clear_req,
    input wire logic             program_halt,
    input wire logic             err_indicator,
    input wire logic             irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic clr_w;
    // Clear arrives by pin or by the control register
    assign clr_w = err_clear_req || (reg_wr &&
                   reg_wdata[`ELOG_CTRL_CLEAR_BIT] &&
                   reg_addr == `ELOG_OFF_CTRL);
    a_halt_on_fatal: assert property (ce && fatal_user_alarm |=> program_halt)
        else $error("no halt after fatal alarm");
    a_halt_holds: assert property (ce && program_halt && !clr_w |=> program_halt)
        else $error("halt dropped without clear");
    a_halt_clear: assert property (ce && clr_w && !fatal_user_alarm |=> !program_halt)
        else $error("halt kept after clear");
    a_nonfatal_runs: assert property (!program_halt && !fatal_user_alarm |=> !program_halt)
        else $error("halt without fatal alarm");
    a_ind_steady: assert property (program_halt |-> err_indicator)
        else $error("indicator off while halted");
    a_reset_quiet: assert property (disable iff (1'b0)
        !rstn |=> !program_halt && !err_indicator && !irq)
        else $error("outputs active in reset");
    a_ptr_bound: assert property (ce && reg_rd && reg_addr == `ELOG_OFF_LOG_PTR
        |=> reg_rdata <= 32'(DEPTH))
        else $error("pointer above depth");
    a_fatal_bit: assert property (ce && reg_rd && reg_addr == `ELOG_OFF_FATAL_STAT
        |=> reg_rdata == (32'($past(program_halt)) << 6))
        else $error("fatal status bit wrong");
    a_irq_masked: assert property (ce && reg_wr && reg_addr == `ELOG_OFF_IRQ_EN &&
        reg_wdata[3:0] == 4'h0 |=> ##1 !irq)
        else $error("irq while all masked");
endmodule : error_log_alarm_unit_checker
bind error_log_alarm_unit error_log_alarm_unit_checker #(.DEPTH(DEPTH),
    .NUM_W(NUM_W), .FLASH_HALF_CYC(FLASH_HALF_CYC)) i_chk (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sys_err_valid(sys_err_valid),
    .sys_err_code(sys_err_code), .sys_err_detail(sys_err_detail),
    .nonfatal_user_alarm(nonfatal_user_alarm),
    .nonfatal_alarm_num(nonfatal_alarm_num),
    .fatal_user_alarm(fatal_user_alarm), .fatal_alarm_num(fatal_alarm_num),
    .err_clear_req(err_clear_req), .program_halt(program_halt),
    .err_indicator(err_indicator), .irq(irq));
`default_nettype wire

// [tb/error_log_alarm_unit_tb.sv]
// Self-checking bench for the error log and alarm unit
`timescale 1ns/10ps
`default_nettype none
`include "error_log_regs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module error_log_alarm_unit_tb;
    logic        core_clk = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0]  reg_addr = 0, nonfatal_alarm_num = 0, fatal_alarm_num = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, seed = 32'hf2ebb422;
    logic [15:0] sys_err_code = 0, sys_err_detail = 0;
    logic        sys_err_valid = 0, nonfatal_user_alarm = 0;
    logic        fatal_user_alarm = 0, err_clear_req = 0;
    logic        program_halt, err_indicator, irq;
    int          errors = 0, total_checks = 0, ptr = 0, code = 0;
    int          f_nf = 0, f_fa = 0, ones;
    int          q_code[$], q_det[$];

    always #50 core_clk = ~core_clk;

    error_log_alarm_unit #(.FLASH_HALF_CYC(4)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sys_err_valid(sys_err_valid),
        .sys_err_code(sys_err_code), .sys_err_detail(sys_err_detail),
        .nonfatal_user_alarm(nonfatal_user_alarm),
        .nonfatal_alarm_num(nonfatal_alarm_num),
        .fatal_user_alarm(fatal_user_alarm), .fatal_alarm_num(fatal_alarm_num),
        .err_clear_req(err_clear_req), .program_halt(program_halt),
        .err_indicator(err_indicator), .irq(irq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input int e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, 32'(e))
    endtask : rd

    // Kind 0 system error, 1 non-fatal, 2 fatal, 3 clear request
    task automatic ev(input int k, input logic [15:0] c, input logic [7:0] n);
        @(posedge core_clk);
        sys_err_valid       <= (k == 0);
        sys_err_code        <= c;
        sys_err_detail      <= ~c;
        nonfatal_user_alarm <= (k == 1);
        nonfatal_alarm_num  <= n;
        fatal_user_alarm    <= (k == 2);
        fatal_alarm_num     <= n;
        err_clear_req       <= (k == 3);
        @(posedge core_clk);
        sys_err_valid       <= 1'b0;
        nonfatal_user_alarm <= 1'b0;
        fatal_user_alarm    <= 1'b0;
        err_clear_req       <= 1'b0;
        if (k == 3) begin
            f_nf = 0;
            f_fa = 0;
            code = 0;
        end else if (k == 1 && n == 0) begin
            f_nf = 0;
        end else begin
            code = (k == 0) ? c : (k == 1) ? (`ELOG_NFATAL_BASE | n)
                                            : (`ELOG_FATAL_BASE | n);
            q_code.push_back(code);
            q_det.push_back((k == 0) ? 16'(~c) : n);
            // Full log drops the oldest slot
            if (q_code.size() > 20) begin
                void'(q_code.pop_front());
                void'(q_det.pop_front());
            end
            ptr = (ptr == 20) ? 20 : ptr + 1;
            if (k == 1) f_nf = 1;
            if (k == 2) f_fa = 1;
        end
    endtask : ev

    task automatic chk_all();
        repeat (2) @(posedge core_clk);
        rd(`ELOG_OFF_ERR_CODE, code);
        rd(`ELOG_OFF_LOG_PTR, ptr);
        rd(`ELOG_OFF_FATAL_STAT, f_fa << 6);
        rd(`ELOG_OFF_NFATAL_STAT, f_nf << 15);
        `CHK(program_halt, 1'(f_fa))
        for (int i = 0; i < q_code.size(); i++) begin
            wr(`ELOG_OFF_LOG_SEL, i);
            @(posedge core_clk);
            rd(`ELOG_OFF_LOG_CODE, q_code[i]);
            rd(`ELOG_OFF_LOG_DETAIL, q_det[i]);
            rd(`ELOG_OFF_LOG_TIME, `ELOG_TIME_CONST);
        end
    endtask : chk_all

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        #1000000;
        errors++;
        $display("[FAIL] %0t run timed out", $time);
        finish_test();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        `CHK({program_halt, err_indicator, irq}, 3'b000)
        chk_all();
        rd(8'h3c, 0);
        rd(`ELOG_OFF_IRQ_EN, 0);
        // Frozen clock enable must swallow an event
        @(posedge core_clk);
        ce            <= 1'b0;
        sys_err_valid <= 1'b1;
        @(posedge core_clk);
        ce            <= 1'b1;
        sys_err_valid <= 1'b0;
        chk_all();
        // Interrupt raised, cleared, then masked
        wr(`ELOG_OFF_IRQ_EN, 32'hf);
        seed = lfsr(seed);
        ev(0, seed[15:0], 8'h00);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        rd(`ELOG_OFF_IRQ_STAT, 1);
        wr(`ELOG_OFF_IRQ_CLR, 32'hf);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        ev(0, seed[31:16], 8'h00);
        wr(`ELOG_OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        // Overfill the log to force shifting and saturation
        for (int i = 0; i < 22; i++) begin
            seed = lfsr(seed);
            ev(0, seed[15:0], 8'h00);
        end
        chk_all();
        rd(`ELOG_OFF_LOG_PTR, 20);
        rd(`ELOG_OFF_IRQ_STAT, 9);
        seed = lfsr(seed);
        ev(1, 16'h0, seed[7:0] | 8'h01);
        chk_all();
        ones = 0;
        repeat (16) begin
            @(posedge core_clk);
            #1;
            ones += int'(err_indicator);
        end
        `CHK(ones, 8)
        ev(1, 16'h0, 8'h00);
        repeat (2) @(posedge core_clk);
        rd(`ELOG_OFF_NFATAL_STAT, 0);
        ev(1, 16'h0, 8'h5a);
        ev(3, 16'h0, 8'h00);
        chk_all();
        ev(2, 16'h0, 8'h03);
        chk_all();
        `CHK(err_indicator, 1'b1)
        rd(`ELOG_OFF_IRQ_STAT, 15);
        // Software has removed the cause before this clear
        wr(`ELOG_OFF_CTRL, 32'h1);
        f_fa = 0;
        f_nf = 0;
        code = 0;
        chk_all();
        // Reset in mid-run with a fatal alarm standing
        ev(2, 16'h0, 8'h07);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        `CHK({program_halt, err_indicator, irq}, 3'b000)
        q_code.delete();
        q_det.delete();
        ptr  = 0;
        code = 0;
        f_fa = 0;
        f_nf = 0;
        chk_all();
        rd(`ELOG_OFF_IRQ_EN, 0);
        finish_test();
    end
endmodule : error_log_alarm_unit_tb
`default_nettype wire
